/* File: shared/adc_ctrl_pkg.sv */
/*
 Package for the converter control block: widths, mux select codes, span codes, timing counts.
 Assumes a 100 MHz system clock.
*/
package adc_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESULT_BITS = 12;
	localparam int ADDR_BITS = 4;
	localparam int LATCH_BITS = RESULT_BITS + ADDR_BITS;
	localparam int TRIAL_IDX_BITS = 4;
	localparam int ACQUIRE_NS = 150;
	localparam int ACQUIRE_CYCLES = (ACQUIRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACQ_CNT_BITS = 5;
	localparam logic [3:0] NEG_SEL_RETURN = 4'h8;
	localparam logic [3:0] NEG_SEL_NONE = 4'hF;
	localparam logic [1:0] SPAN_UNI_HALF = 2'h0;
	localparam logic [1:0] SPAN_UNI_FULL = 2'h1;
	localparam logic [1:0] SPAN_BIP_QUARTER = 2'h2;
	localparam logic [1:0] SPAN_BIP_HALF = 2'h3;
	localparam logic [RESULT_BITS-1:0] TRIAL_RESET = 12'h000;
	localparam logic [LATCH_BITS-1:0] LATCH_RESET = 16'h0000;

	typedef enum logic [1:0] {
		st_idle,
		st_convert,
		st_load
	} conv_state_t;
endpackage

/* File: verilog/mux_select_decode.sv */
/*
 Input multiplexer select decode: positive and negative input numbers, gain and span code.
 Assumes select inputs are already latched by the caller.
*/
`timescale 1ns/100ps
module mux_select_decode
	import adc_ctrl_pkg::*;
(
	input wire logic pair_mode_select_in,
	input wire logic [2:0] chan_addr_in,
	input wire logic gain_select_in,
	input wire logic polarity_select_in,
	output logic [3:0] pos_sel_out,
	output logic [3:0] neg_sel_out,
	output logic [7:0] pos_onehot_out,
	output logic return_used_out,
	output logic [1:0] gain_out,
	output logic [1:0] span_code_out
);
	always_comb
	begin
		if (pair_mode_select_in)
		begin
			// Pair picked by upper bits, polarity by bit 0
			pos_sel_out = {1'b0, chan_addr_in[2:1], chan_addr_in[0]};
			neg_sel_out = {1'b0, chan_addr_in[2:1], ~chan_addr_in[0]};
			return_used_out = 1'b0;
		end
		else
		begin
			pos_sel_out = {1'b0, chan_addr_in};
			neg_sel_out = NEG_SEL_RETURN;
			return_used_out = 1'b1;
		end
		pos_onehot_out = 8'h01 << pos_sel_out[2:0];
		gain_out = gain_select_in ? 2'h1 : 2'h2;
		// Polarity then gain, as the four span codes
		span_code_out = {polarity_select_in, gain_select_in};
	end
endmodule

/* File: verilog/bit_trial_engine.sv */
/*
 Successive approximation engine: clears on start, trials MSB first, one bit per cycle.
 Assumes the comparator answer is valid for the trial word presented in the same cycle.
*/
`timescale 1ns/100ps
module bit_trial_engine
	import adc_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	input wire logic cmp_high_in,
	output logic [RESULT_BITS-1:0] trial_word_out,
	output logic [RESULT_BITS-1:0] bit_trial_register_out,
	output logic done_out
);
	logic [TRIAL_IDX_BITS-1:0] idx;
	logic running;
	logic [RESULT_BITS-1:0] test_bit;

	assign test_bit = {{(RESULT_BITS-1){1'b0}}, 1'b1} << idx;
	assign trial_word_out = bit_trial_register_out | test_bit;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			running <= 1'b0;
			idx <= '0;
			done_out <= 1'b0;
			bit_trial_register_out <= TRIAL_RESET;
		end
		else if (start_in && !running)
		begin
			// Clear before the first decision
			bit_trial_register_out <= TRIAL_RESET;
			idx <= TRIAL_IDX_BITS'(RESULT_BITS - 1);
			running <= 1'b1;
			done_out <= 1'b0;
		end
		else if (running)
		begin
			if (cmp_high_in)
				bit_trial_register_out <= trial_word_out;
			if (idx == '0)
			begin
				running <= 1'b0;
				done_out <= 1'b1;
			end
			else
				idx <= idx - 1'b1;
		end
		else
			done_out <= 1'b0;
	end
endmodule

/* File: verilog/adc_mux_select_and_conversion_control.sv */
/*
 Digital side of an eight-input successive-approximation converter: select latching,
 mux decode, conversion sequencing, output latch and read drivers.
 Assumes all host strobes are synchronous to clk_in; the analog comparator is a port.
*/
`timescale 1ns/100ps
module adc_mux_select_and_conversion_control
	import adc_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_select_n_in,
	input wire logic conv_start_n_in,
	input wire logic read_n_in,
	input wire logic write_n_in,
	input wire logic pair_mode_select_in,
	input wire logic chan_addr_bit2_in,
	input wire logic chan_addr_bit1_in,
	input wire logic chan_addr_bit0_in,
	input wire logic gain_select_in,
	input wire logic polarity_select_in,
	input wire logic cmp_high_in,
	output logic [3:0] pos_sel_out,
	output logic [3:0] neg_sel_out,
	output logic [7:0] pos_onehot_out,
	output logic return_used_out,
	output logic [1:0] gain_out,
	output logic [1:0] span_code_out,
	output logic hold_capacitor_sample_out,
	output logic [RESULT_BITS-1:0] dac_trial_out,
	output logic busy_out,
	output logic acquire_done_out,
	output logic [LATCH_BITS-1:0] data_out,
	output logic data_oe_out
);
	// ------------------------------------------------------------
	// Select capture
	// ------------------------------------------------------------
	logic pair_mode;
	logic [2:0] chan_addr;
	logic gain_sel;
	logic pol_sel;
	logic [2:0] conv_addr;
	logic conv_pair;

	// Reloaded on every clock edge while write is low, holds once write is high
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pair_mode <= 1'b0;
			chan_addr <= 3'h0;
			gain_sel <= 1'b0;
			pol_sel <= 1'b0;
		end
		else if (!write_n_in)
		begin
			pair_mode <= pair_mode_select_in;
			chan_addr <= {chan_addr_bit2_in, chan_addr_bit1_in, chan_addr_bit0_in};
			gain_sel <= gain_select_in;
			pol_sel <= polarity_select_in;
		end
	end

	mux_select_decode u_decode (
		.pair_mode_select_in(pair_mode),
		.chan_addr_in(chan_addr),
		.gain_select_in(gain_sel),
		.polarity_select_in(pol_sel),
		.pos_sel_out(pos_sel_out),
		.neg_sel_out(neg_sel_out),
		.pos_onehot_out(pos_onehot_out),
		.return_used_out(return_used_out),
		.gain_out(gain_out),
		.span_code_out(span_code_out)
	);

	// ------------------------------------------------------------
	// Start detection
	// ------------------------------------------------------------
	logic conv_start_prev;
	logic start_fall;
	logic start_req;
	conv_state_t state;
	conv_state_t next_state;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			conv_start_prev <= 1'b1;
		else
			conv_start_prev <= conv_start_n_in;
	end

	assign start_fall = conv_start_prev && !conv_start_n_in;
	// Requests during a conversion are dropped, not queued
	assign start_req = start_fall && !chip_select_n_in && (state == st_idle);

	// ------------------------------------------------------------
	// Conversion sequence
	// ------------------------------------------------------------
	logic trial_done;
	logic [RESULT_BITS-1:0] trial_result;

	bit_trial_engine u_engine (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start_req),
		.cmp_high_in(cmp_high_in),
		.trial_word_out(dac_trial_out),
		.bit_trial_register_out(trial_result),
		.done_out(trial_done)
	);

	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:
				if (start_req)
					next_state = st_convert;
			st_convert:
				if (trial_done)
					next_state = st_load;
			st_load:
				next_state = st_idle;
			default:
				next_state = st_idle;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			state <= st_idle;
		else
			state <= next_state;
	end

	// Channel code used by this conversion is frozen at its start
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			conv_addr <= 3'h0;
			conv_pair <= 1'b0;
		end
		else if (start_req)
		begin
			conv_addr <= chan_addr;
			conv_pair <= pair_mode;
		end
	end

	// ------------------------------------------------------------
	// Output latch and busy
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			data_out <= LATCH_RESET;
		else if (state == st_load)
			// Comparator sees positive minus negative; the low 12 bits are that difference, topped by the pair flag and channel code
			data_out <= {conv_pair, conv_addr, trial_result};
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			busy_out <= 1'b0;
		else if (start_req)
			busy_out <= 1'b1;
		else if (state == st_load)
			busy_out <= 1'b0;
	end

	assign hold_capacitor_sample_out = (state == st_idle);
	assign data_oe_out = !read_n_in && !chip_select_n_in;

	// ------------------------------------------------------------
	// Acquire timer
	// ------------------------------------------------------------
	// Only informs the host; a start before it expires is still honoured
	logic [ACQ_CNT_BITS-1:0] acq_cnt;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			acq_cnt <= ACQ_CNT_BITS'(ACQUIRE_CYCLES);
		else if (state != st_idle)
			acq_cnt <= '0;
		else if (acq_cnt != ACQ_CNT_BITS'(ACQUIRE_CYCLES))
			acq_cnt <= acq_cnt + 1'b1;
	end

	assign acquire_done_out = (acq_cnt == ACQ_CNT_BITS'(ACQUIRE_CYCLES));
endmodule

/* File: testbench/adc_ctrl_asserts.sv */
/*
 Port checker for the converter control block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module adc_ctrl_checker (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic chip_select_n_in,
	input wire logic conv_start_n_in,
	input wire logic read_n_in,
	input wire logic busy_out,
	input wire logic data_oe_out,
	input wire logic return_used_out,
	input wire logic [3:0] pos_sel_out,
	input wire logic [3:0] neg_sel_out,
	input wire logic [7:0] pos_onehot_out,
	input wire logic [11:0] dac_trial_out,
	input wire logic [15:0] data_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_start_busy:
		assert property (!busy_out && !chip_select_n_in && $fell(conv_start_n_in) |=> busy_out)
		else $error("start not taken");
	a_cs_gate:
		assert property (!busy_out && chip_select_n_in |=> !busy_out) else $error("start unselected");
	a_busy_span:
		assert property ($rose(busy_out) |-> busy_out[*7] ##1 busy_out[*7] ##1 !busy_out)
		else $error("busy length");
	a_data_hold:
		assert property ($changed(data_out) |-> $fell(busy_out)) else $error("latch moved");
	a_trial_clear:
		assert property ($rose(busy_out) |-> dac_trial_out == 12'h800) else $error("no clear");
	a_msb_first:
		assert property ($rose(busy_out) |=> dac_trial_out[10]) else $error("bit order");
	a_oe_gate:
		assert property (data_oe_out == (!read_n_in && !chip_select_n_in)) else $error("oe");
	a_return_use:
		assert property (return_used_out == (neg_sel_out == 4'h8)) else $error("return use");
	a_pos_onehot:
		assert property (pos_onehot_out == 8'h01 << pos_sel_out) else $error("onehot");
endmodule

/* File: testbench/cmp_model.sv */
/*
 Comparator stand-in: judges each trial word against a held input difference.
 Assumes the level is the settled positive minus negative input.
*/
`timescale 1ns/100ps
module cmp_model (
	input wire logic [11:0] trial_in,
	input wire logic [11:0] level_in,
	output logic keep_out
);
	// Keep the bit while the trial does not overshoot the input
	assign keep_out = trial_in <= level_in;
endmodule

/* File: testbench/tb_top.sv */
/*
 Self-checking bench: all 16 pair/channel codes, random gain, polarity and levels, conversions with a stray restart.
 Assumes the package, design, comparator model and checker are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
	import adc_ctrl_pkg::*;
	logic clk_in = 0, sys_rst_in = 1, cs_n = 1, cv_n = 1, rd_n = 1, wr_n = 1;
	logic pm = 0, g = 0, pol = 0, keep, busy, acq, oe, ret, hold;
	logic [2:0] a = 0;
	logic [11:0] lvl = 0, trial;
	logic [3:0] ps, ns;
	logic [7:0] oh;
	logic [1:0] gn, sp;
	logic [15:0] dq;
	int mismatches = 0, n_checks = 0, seed = 85107, k;
	always #5 clk_in = ~clk_in;
	adc_mux_select_and_conversion_control dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.chip_select_n_in(cs_n), .conv_start_n_in(cv_n), .read_n_in(rd_n), .write_n_in(wr_n),
		.pair_mode_select_in(pm), .chan_addr_bit2_in(a[2]), .chan_addr_bit1_in(a[1]),
		.chan_addr_bit0_in(a[0]), .gain_select_in(g), .polarity_select_in(pol),
		.cmp_high_in(keep), .pos_sel_out(ps), .neg_sel_out(ns), .pos_onehot_out(oh),
		.return_used_out(ret), .gain_out(gn), .span_code_out(sp), .hold_capacitor_sample_out(hold),
		.dac_trial_out(trial), .busy_out(busy), .acquire_done_out(acq), .data_out(dq),
		.data_oe_out(oe));
	cmp_model cmp (.trial_in(trial), .level_in(lvl), .keep_out(keep));
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A second falling start mid-conversion must not stretch or restart it
	task conv(input logic [15:0] exp);
		int n, h;
		n = 0;
		h = 0;
		@(posedge clk_in) cs_n <= 0;
		@(posedge clk_in) cv_n <= 0;
		@(posedge clk_in) cv_n <= 1;
		repeat (20)
		begin
			@(posedge clk_in) cv_n <= (n != 4);
			@(negedge clk_in) n += busy === 1'b1;
			h += hold === 1'b0;
		end
		chk("busy cycles", 13, n);
		chk("sample off cycles", 13, h);
		chk("latch", exp, dq);
		chk("acquire early", 0, acq);
		repeat (16) @(posedge clk_in);
		@(negedge clk_in) chk("acquire", 1, acq);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_in);
		sys_rst_in <= 0;
		for (k = 0; k < 16; k++)
		begin
			@(posedge clk_in) {pm, a} <= 4'(k);
			{g, pol} <= 2'($random(seed));
			lvl <= 12'($random(seed));
			wr_n <= 0;
			@(posedge clk_in) wr_n <= 1;
			@(negedge clk_in) chk("pos", a, ps);
			chk("neg", pm ? {1'b0, a ^ 3'h1} : 4'h8, ns);
			chk("return", !pm, ret);
			chk("onehot", 8'h01 << a, oh);
			chk("hold", 1, hold);
			chk("gain", g ? 1 : 2, gn);
			chk("span", {pol, g}, sp);
			conv({pm, a, lvl});
		end
		@(posedge clk_in) cs_n <= 1;
		cv_n <= 0;
		rd_n <= 0;
		@(negedge clk_in) chk("oe", 0, oe);
		repeat (3) @(posedge clk_in);
		@(negedge clk_in) chk("busy", 0, busy);
		@(posedge clk_in) cs_n <= 0;
		@(negedge clk_in) chk("oe", 1, oe);
		close_out;
	end
	initial
	begin
		#50000;
		mismatches++;
		close_out;
	end
endmodule
bind adc_mux_select_and_conversion_control adc_ctrl_checker chk_i (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .chip_select_n_in(chip_select_n_in),
	.conv_start_n_in(conv_start_n_in), .read_n_in(read_n_in), .busy_out(busy_out),
	.data_oe_out(data_oe_out), .return_used_out(return_used_out), .pos_sel_out(pos_sel_out),
	.neg_sel_out(neg_sel_out), .pos_onehot_out(pos_onehot_out), .dac_trial_out(dac_trial_out),
	.data_out(data_out));
